// ==== occ_map.svh ====
// Register offsets, field positions, reset values and timing counts for the oscillator control.
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH
`define OCC_OFS_CTRL 4'h0
`define OCC_OFS_CTRL2 4'h4
`define OCC_OFS_TUNE 4'h8
`define OCC_OFS_CFG 4'hC
`define OCC_CTRL_IDLE 7
`define OCC_CTRL_FREQ_HI 6
`define OCC_CTRL_FREQ_LO 4
`define OCC_CTRL_STARTUP 3
`define OCC_CTRL_FAST_OK 2
`define OCC_CTRL2_SEC_ACT 6
`define OCC_CTRL2_SEC_DRV 4
`define OCC_CTRL2_SEC_GO 3
`define OCC_CTRL2_MID_OK 1
`define OCC_CTRL2_MID_SEL 0
`define OCC_TUNE_LF_SRC 7
`define OCC_TUNE_MULT 6
`define OCC_FREQ_RESET 3'h6
`define OCC_OLD_CYCLES 3'h2
`define OCC_NEW_CYCLES 3'h4
`endif

// ==== occ_pkg.sv ====
// Types shared by the oscillator control block.
package occ_pkg;
    typedef enum logic [2:0] {
        OCC_RUN = 3'h1,
        OCC_OLD = 3'h2,
        OCC_NEW = 3'h4
    } occ_sw_e;
    typedef enum logic [2:0] {
        OCC_SRC_PRIMARY = 3'h1,
        OCC_SRC_SECONDARY = 3'h2,
        OCC_SRC_INTERNAL = 3'h4
    } occ_src_e;
    typedef enum logic [3:0] {
        OCC_OSC_FAST = 4'h1,
        OCC_OSC_MID = 4'h2,
        OCC_OSC_SLOW = 4'h4,
        OCC_OSC_NONE = 4'h8
    } occ_osc_e;
    typedef struct packed {
        logic idle_on_sleep_select;
        logic [2:0] internal_freq_select;
        logic [1:0] system_clock_select;
        logic secondary_high_drive;
        logic secondary_keep_running;
        logic mid_internal_select;
        logic low_freq_source_select;
        logic multiplier_enable;
        logic [5:0] internal_trim;
        logic [2:0] startup_sync;
        logic [2:0] fast_sync;
        logic [2:0] sec_sync;
        logic [2:0] mid_sync;
        logic primary_startup_done;
        logic fast_internal_stable;
        logic secondary_clock_active;
        logic mid_internal_stable;
        logic startup_seeded;
        occ_sw_e sw_state;
        logic [2:0] sw_count;
        occ_src_e active_src;
        occ_src_e target_src;
        logic aw_held;
        logic [3:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } occ_state_s;
endpackage

// ==== occ_ctrl.sv ====
// Oscillator control registers with AXI4-Lite access and clock switch sequencing.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "occ_map.svh"
module occ_ctrl
    import occ_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data.
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Configuration straps and analogue status.
    input wire logic two_speed_startup_cfg,
    input wire logic [1:0] secondary_mode_cfg,
    input wire logic internal_primary_cfg,
    input wire logic startup_timer_done,
    input wire logic fast_osc_stable,
    input wire logic mid_osc_stable,
    input wire logic sleep_request,
    // Clock tree controls.
    output logic sleep_enter,
    output logic idle_enter,
    output logic [2:0] int_divide_log2,
    output logic div_by_512,
    output occ_osc_e int_osc_select,
    output occ_src_e sys_clk_source,
    output logic sys_clk_hold,
    output logic secondary_high_power,
    output logic secondary_enable,
    output logic multiplier_on,
    output logic [5:0] trim_code
);

    occ_state_s s_q;
    occ_state_s s_d;

    // Decodes the clock select field into a source.
    function automatic occ_src_e src_of(input logic [1:0] sel);
        if (sel[1])
        begin
            return OCC_SRC_INTERNAL;
        end
        else if (sel[0])
        begin
            return OCC_SRC_SECONDARY;
        end
        return OCC_SRC_PRIMARY;
    endfunction

    // True when the internal block is the device clock for a given source.
    function automatic logic internal_clocks(input occ_src_e src, input logic prim_int);
        return (src == OCC_SRC_INTERNAL) || (src == OCC_SRC_PRIMARY && prim_int);
    endfunction

    logic digital_mode;
    logic rd_hit;
    logic [31:0] rd_word;
    logic [3:0] ar_idx;
    logic do_write;
    logic int_active;

    assign digital_mode = (secondary_mode_cfg == 2'h2);
    // Addresses beyond the register window fold onto an unmapped index and answer with an error.
    assign ar_idx = (s_axi_araddr[31:4] == 28'h0) ? s_axi_araddr[3:0] : 4'h1;
    assign do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    // Read word decode; unimplemented bits read zero.
    always_comb
    begin
        rd_hit = 1'b1;
        rd_word = 32'h0;
        case (ar_idx)
            `OCC_OFS_CTRL:
            begin
                rd_word[7:0] = {s_q.idle_on_sleep_select, s_q.internal_freq_select,
                    s_q.primary_startup_done, s_q.fast_internal_stable,
                    s_q.system_clock_select};
            end
            `OCC_OFS_CTRL2:
            begin
                rd_word[7:0] = {1'b0, s_q.secondary_clock_active, 1'b0,
                    s_q.secondary_high_drive, s_q.secondary_keep_running, 1'b0,
                    s_q.mid_internal_stable, s_q.mid_internal_select};
            end
            `OCC_OFS_TUNE:
            begin
                rd_word[7:0] = {s_q.low_freq_source_select, s_q.multiplier_enable,
                    s_q.internal_trim};
            end
            `OCC_OFS_CFG:
            begin
                rd_word[2:0] = s_q.active_src;
            end
            default:
            begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        s_d = s_q;
        s_d.startup_sync = {s_q.startup_sync[1:0], startup_timer_done};
        s_d.fast_sync = {s_q.fast_sync[1:0], fast_osc_stable};
        s_d.mid_sync = {s_q.mid_sync[1:0], mid_osc_stable};
        s_d.sec_sync = {s_q.sec_sync[1:0], s_q.active_src == OCC_SRC_SECONDARY};
        if (s_q.fast_sync[1] == s_q.fast_sync[2])
        begin
            s_d.fast_internal_stable = s_q.fast_sync[2];
        end
        if (s_q.mid_sync[1] == s_q.mid_sync[2])
        begin
            s_d.mid_internal_stable = s_q.mid_sync[2];
        end
        s_d.secondary_clock_active = s_q.sec_sync[2];
        // Seed start-up flag from strap after release.
        if (!s_q.startup_seeded)
        begin
            s_d.startup_seeded = 1'b1;
            s_d.primary_startup_done = !two_speed_startup_cfg;
        end
        // Start-up done once timer expired and primary runs.
        else if (s_q.startup_sync[1] == s_q.startup_sync[2])
        begin
            s_d.primary_startup_done = s_q.startup_sync[2]
                && s_q.active_src == OCC_SRC_PRIMARY && s_q.sw_state == OCC_RUN;
        end
        // AXI write channel capture in either order.
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = (s_axi_awaddr[31:4] == 28'h0) ? s_axi_awaddr[3:0] : 4'h1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (do_write)
        begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = 2'h0;
            case (s_q.aw_addr)
                `OCC_OFS_CTRL:
                begin
                    if (s_q.w_strb[0])
                    begin
                        s_d.idle_on_sleep_select = s_q.w_data[`OCC_CTRL_IDLE];
                        s_d.internal_freq_select =
                            s_q.w_data[`OCC_CTRL_FREQ_HI:`OCC_CTRL_FREQ_LO];
                        s_d.system_clock_select = s_q.w_data[1:0];
                    end
                end
                `OCC_OFS_CTRL2:
                begin
                    if (s_q.w_strb[0])
                    begin
                        s_d.secondary_high_drive = s_q.w_data[`OCC_CTRL2_SEC_DRV];
                        s_d.secondary_keep_running = s_q.w_data[`OCC_CTRL2_SEC_GO];
                        s_d.mid_internal_select = s_q.w_data[`OCC_CTRL2_MID_SEL];
                    end
                end
                `OCC_OFS_TUNE:
                begin
                    if (s_q.w_strb[0])
                    begin
                        s_d.low_freq_source_select = s_q.w_data[`OCC_TUNE_LF_SRC];
                        s_d.multiplier_enable = s_q.w_data[`OCC_TUNE_MULT];
                        s_d.internal_trim = s_q.w_data[5:0];
                    end
                end
                `OCC_OFS_CFG:
                begin
                end
                default:
                begin
                    s_d.bresp = 2'h2;
                end
            endcase
        end
        if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
        end
        // AXI read.
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_word;
            s_d.rresp = rd_hit ? 2'h0 : 2'h2;
        end
        else if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end
        case (s_q.sw_state)
            OCC_RUN:
            begin
                if (src_of(s_d.system_clock_select) != s_q.active_src)
                begin
                    s_d.target_src = src_of(s_d.system_clock_select);
                    s_d.sw_count = `OCC_OLD_CYCLES;
                    s_d.sw_state = OCC_OLD;
                end
            end
            // Two old cycles then four new.
            OCC_OLD:
            begin
                if (s_q.sw_count == 3'h1)
                begin
                    s_d.active_src = s_q.target_src;
                    s_d.sw_count = `OCC_NEW_CYCLES;
                    s_d.sw_state = OCC_NEW;
                end
                else
                begin
                    s_d.sw_count = s_q.sw_count - 3'h1;
                end
            end
            OCC_NEW:
            begin
                if (s_q.sw_count == 3'h1)
                begin
                    s_d.sw_state = OCC_RUN;
                end
                else
                begin
                    s_d.sw_count = s_q.sw_count - 3'h1;
                end
            end
            default:
            begin
                s_d.sw_state = OCC_RUN;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
            s_q.internal_freq_select <= `OCC_FREQ_RESET;
            s_q.sw_state <= OCC_RUN;
            s_q.active_src <= OCC_SRC_PRIMARY;
            s_q.target_src <= OCC_SRC_PRIMARY;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign int_active = internal_clocks(s_q.active_src, internal_primary_cfg);

    // Oscillator and divider selection for the internal block.
    always_comb
    begin
        int_divide_log2 = 3'h0;
        div_by_512 = 1'b0;
        int_osc_select = OCC_OSC_FAST;
        // Fast oscillator divide 1 to 16.
        if (s_q.internal_freq_select[2] || s_q.internal_freq_select == 3'h3)
        begin
            int_divide_log2 = 3'h7 - s_q.internal_freq_select;
        end
        else if (s_q.mid_internal_select)
        begin
            int_osc_select = OCC_OSC_MID;
            // Mid divide 1, 2, 16 or slow oscillator.
            case (s_q.internal_freq_select)
                3'h2: int_divide_log2 = 3'h0;
                3'h1: int_divide_log2 = 3'h1;
                default:
                begin
                    int_divide_log2 = s_q.low_freq_source_select ? 3'h4 : 3'h0;
                    int_osc_select = s_q.low_freq_source_select ? OCC_OSC_MID : OCC_OSC_SLOW;
                end
            endcase
        end
        else
        begin
            // Divide 32, 64, 512 or slow oscillator.
            case (s_q.internal_freq_select)
                3'h2: int_divide_log2 = 3'h5;
                3'h1: int_divide_log2 = 3'h6;
                default:
                begin
                    div_by_512 = s_q.low_freq_source_select;
                    int_osc_select = s_q.low_freq_source_select ? OCC_OSC_FAST : OCC_OSC_SLOW;
                end
            endcase
        end
    end

    // Active source drives the clock mux.
    assign sys_clk_source = s_q.active_src;
    assign sys_clk_hold = (s_q.sw_state != OCC_RUN);
    assign idle_enter = sleep_request && s_q.idle_on_sleep_select;
    assign sleep_enter = sleep_request && !s_q.idle_on_sleep_select;
    assign secondary_high_power = digital_mode ? 1'b0
        : (s_q.secondary_high_drive || secondary_mode_cfg == 2'h3);
    assign secondary_enable = digital_mode
        || s_q.secondary_keep_running || s_q.active_src == OCC_SRC_SECONDARY;
    // Internal clock only at 4, 8 or 16 MHz.
    assign multiplier_on = s_q.multiplier_enable
        && (!int_active || s_q.internal_freq_select >= 3'h5);
    // Signed trim passed to the oscillator.
    assign trim_code = s_q.internal_trim;

endmodule // occ_ctrl

// ==== occ_ctrl_chk.sv ====
// Port checker for the oscillator control block.
`timescale 1ns/100ps
module occ_ctrl_chk
    import occ_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus handshakes.
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // Clock tree side.
    input wire logic [1:0] secondary_mode_cfg,
    input wire logic sleep_request,
    input wire logic sleep_enter,
    input wire logic idle_enter,
    input wire occ_src_e sys_clk_source,
    input wire logic sys_clk_hold,
    input wire logic secondary_high_power
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_sleep_kind: assert property (sleep_request |-> sleep_enter != idle_enter)
        else $error("sleep kind wrong");
    a_sleep_quiet: assert property (!sleep_request |-> !sleep_enter && !idle_enter)
        else $error("sleep entered without request");
    a_pause_len: assert property ($rose(sys_clk_hold) |-> sys_clk_hold [*6] ##1 !sys_clk_hold)
        else $error("switch pause length wrong");
    a_switch_late: assert property ($changed(sys_clk_source) |-> sys_clk_hold && $past(sys_clk_hold, 2))
        else $error("source changed outside pause");
    a_src_onehot: assert property ($onehot(sys_clk_source))
        else $error("clock source not one-hot");
    a_high_power: assert property (secondary_mode_cfg == 2'h3 |-> secondary_high_power)
        else $error("high power not selected");
    a_reset_src: assert property (disable iff (1'b0) !aresetn |=> sys_clk_source == OCC_SRC_PRIMARY && !sys_clk_hold)
        else $error("reset left source unchanged");
endmodule // occ_ctrl_chk

bind occ_ctrl occ_ctrl_chk i_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .secondary_mode_cfg,
    .sleep_request, .sleep_enter, .idle_enter, .sys_clk_source, .sys_clk_hold, .secondary_high_power);

// ==== tb_top.sv ====
// Self-checking bench for the oscillator control block.
`timescale 1ns/100ps
`include "occ_map.svh"
module tb_top;
    import occ_pkg::*;
    localparam logic [7:0] ofs_ctrl = {4'h0, `OCC_OFS_CTRL};
    localparam logic [7:0] ofs_ctrl2 = {4'h0, `OCC_OFS_CTRL2};
    localparam logic [7:0] ofs_tune = {4'h0, `OCC_OFS_TUNE};
    localparam logic [7:0] ofs_src = {4'h0, `OCC_OFS_CFG};
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, secondary_mode_cfg, rsp;
    logic two_speed_startup_cfg, internal_primary_cfg, startup_timer_done, fast_osc_stable;
    logic mid_osc_stable, sleep_request, sleep_enter, idle_enter, div_by_512, sys_clk_hold;
    logic secondary_high_power, secondary_enable, multiplier_on;
    logic [2:0] int_divide_log2;
    logic [5:0] trim_code;
    occ_osc_e int_osc_select;
    occ_src_e sys_clk_source;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;

    occ_ctrl i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .two_speed_startup_cfg, .secondary_mode_cfg, .internal_primary_cfg, .startup_timer_done,
        .fast_osc_stable, .mid_osc_stable, .sleep_request, .sleep_enter, .idle_enter,
        .int_divide_log2, .div_by_512, .int_osc_select, .sys_clk_source, .sys_clk_hold,
        .secondary_high_power, .secondary_enable, .multiplier_on, .trim_code
    );

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            final_report();
        end
    end

    task automatic final_report();
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= {24'h000000, a};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do
            @(posedge aclk);
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= {24'h000000, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge aclk);
        while (!(s_axi_arvalid && s_axi_arready));
        s_axi_arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge aclk);
    endtask

    task automatic t_reset();
        axi_rd(ofs_ctrl);
        check(rd, 32'h60);
        axi_rd(ofs_ctrl2);
        check(rd, 32'h00);
        axi_rd(ofs_tune);
        check(rd, 32'h00);
        axi_wr(ofs_ctrl, 8'h6C);
        axi_rd(ofs_ctrl);
        check(rd, 32'h60);
        fast_osc_stable <= 1'b1;
        startup_timer_done <= 1'b1;
        tick(6);
        axi_rd(ofs_ctrl);
        check(rd, 32'h6C);
    endtask

    task automatic t_ctrl2();
        axi_wr(ofs_ctrl2, 8'hFF);
        axi_rd(ofs_ctrl2);
        check(rd, 32'h19);
        mid_osc_stable <= 1'b1;
        tick(6);
        axi_rd(ofs_ctrl2);
        check(rd, 32'h1B);
        check(32'(secondary_enable), 32'h1);
        for (int m = 0; m < 8; m++)
        begin
            secondary_mode_cfg <= m[1:0];
            axi_wr(ofs_ctrl2, {3'h0, m[2], 4'h0});
            check(32'(secondary_high_power), 32'(m[1:0] == 2'h3 || (m[2] && m[1:0] != 2'h2)));
            check(32'(secondary_enable), 32'(m[1:0] == 2'h2));
        end
        secondary_mode_cfg <= 2'h0;
    endtask

    task automatic t_tune();
        axi_wr(ofs_tune, 8'h60);
        axi_rd(ofs_tune);
        check(rd, 32'h60);
        check(32'(trim_code), 32'h20);
        check(32'(multiplier_on), 32'h1);
        axi_wr(ofs_tune, 8'h5F);
        check(32'(trim_code), 32'h1F);
        internal_primary_cfg <= 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            axi_wr(ofs_ctrl, {1'b0, c[2:0], 4'h0});
            check(32'(multiplier_on), 32'(c >= 5));
        end
        axi_wr(ofs_tune, 8'h00);
        check(32'(multiplier_on), 32'h0);
        check(32'(trim_code), 32'h00);
        internal_primary_cfg <= 1'b0;
    endtask

    task automatic t_errors();
        axi_rd(8'h10);
        check(32'(rsp), 32'h2);
        axi_wr(8'h10, 8'hFF);
        check(32'(rsp), 32'h2);
        axi_wr(ofs_ctrl, 8'hE0);
        sleep_request <= 1'b1;
        tick(1);
        check(32'({sleep_enter, idle_enter}), 32'h1);
        axi_wr(ofs_ctrl, 8'h60);
        check(32'({sleep_enter, idle_enter}), 32'h2);
        sleep_request <= 1'b0;
    endtask

    task automatic t_freq();
        occ_osc_e eo;
        logic [2:0] lg;
        for (int s = 0; s < 4; s++)
        begin
            axi_wr(ofs_tune, {s[1], 7'h00});
            axi_wr(ofs_ctrl2, {7'h00, s[0]});
            for (int c = 0; c < 8; c++)
            begin
                axi_wr(ofs_ctrl, {1'b0, c[2:0], 4'h2});
                lg = 3'(7 - c);
                eo = OCC_OSC_FAST;
                if (c < 3 && s[0])
                begin
                    eo = OCC_OSC_MID;
                    lg = (c == 0) ? 3'h4 : 3'(2 - c);
                end
                if (c == 0 && !s[1])
                    eo = OCC_OSC_SLOW;
                check(32'(int_osc_select), 32'(eo));
                check(32'(div_by_512), 32'(c == 0 && s == 2));
                if (eo != OCC_OSC_SLOW && !(c == 0 && s == 2))
                    check(32'(int_divide_log2), 32'(lg));
            end
        end
    endtask

    task automatic t_switch();
        occ_src_e es;
        logic [1:0] sl;
        for (int i = 0; i < 4; i++)
        begin
            sl = 2'(8'h8D >> (2 * i));
            axi_wr(ofs_ctrl, {6'h18, sl});
            tick(8);
            es = sl[1] ? OCC_SRC_INTERNAL : (sl[0] ? OCC_SRC_SECONDARY : OCC_SRC_PRIMARY);
            check(32'(sys_clk_source), 32'(es));
            axi_rd(ofs_src);
            check(rd, 32'(es));
            axi_rd(ofs_ctrl2);
            check(32'(rd[6]), 32'(sl == 2'h1));
            check(32'(secondary_enable), 32'(sl == 2'h1));
            axi_rd(ofs_ctrl);
            check(rd, {24'h000000, 4'h6, sl == 2'h0, 1'b1, sl});
        end
        aresetn <= 1'b0;
        tick(10);
        aresetn <= 1'b1;
        tick(2);
        check(32'(sys_clk_source), 32'(OCC_SRC_PRIMARY));
        axi_rd(ofs_ctrl);
        check(rd & 32'hF3, 32'h60);
    endtask

    initial
    begin
        aresetn = 1'b0;
        s_axi_awaddr = 32'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 32'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        two_speed_startup_cfg = 1'b1;
        secondary_mode_cfg = 2'h0;
        internal_primary_cfg = 1'b0;
        startup_timer_done = 1'b0;
        fast_osc_stable = 1'b0;
        mid_osc_stable = 1'b0;
        sleep_request = 1'b0;
        tick(10);
        aresetn <= 1'b1;
        tick(2);
        t_reset();
        t_ctrl2();
        t_tune();
        t_errors();
        t_freq();
        t_switch();
        final_report();
    end
endmodule // tb_top
